// ---- hw/rtsa_sec_gen.sv ----
`default_nettype none
module rtsa_sec_gen #(
    parameter int OSC_PER_SEC = rtsa_pkg::OSC_HZ
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic osc_edge,
    input wire logic [6:0] trim_code,
    output logic sec_tick,
    output logic [rtsa_pkg::PHASE_W-1:0] sec_phase
);
    localparam int W = rtsa_pkg::PHASE_W;
    localparam logic [W-1:0] NOM = W'(OSC_PER_SEC);
    localparam logic [W-1:0] STEP = W'(rtsa_pkg::TRIM_STEP_CYCLES);
    localparam logic [4:0] LAST_IDX = 5'(rtsa_pkg::TRIM_PERIOD_SEC - 1);
    localparam logic [4:0] PRE_IDX = 5'(rtsa_pkg::TRIM_PERIOD_SEC - 2);

    function automatic logic [6:0] trim_mag(input logic [6:0] code);
        logic [6:0] mag;
        mag = 7'h00;
        if (code[5:0] == 6'h00) begin
            mag = 7'h00; // R2
        end else if (!code[6]) begin
            mag = code - rtsa_pkg::TRIM_POS_BASE; // R3
        end else if (code == rtsa_pkg::TRIM_NEG_NULL) begin
            mag = 7'h00; // R5
        end else begin
            mag = 7'(rtsa_pkg::TRIM_NEG_BASE - {1'b0, code}); // R4
        end
        return mag;
    endfunction

    logic [W-1:0] cnt_r;
    logic [W-1:0] len_r;
    logic [W-1:0] delta;
    logic [4:0] idx_r;
    logic tick_c;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    assign delta = W'(trim_mag(trim_code)) * STEP;
    assign tick_c = osc_edge && (cnt_r == len_r - 1'b1);
    assign sec_phase = cnt_r;

    always_ff @(posedge clock) begin
        if (srst) begin
            cnt_r <= '0;
        end else if (tick_c) begin
            cnt_r <= '0;
        end else if (osc_edge) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // trim is sampled when the last second of the interval starts
    always_ff @(posedge clock) begin
        if (srst) begin
            idx_r <= 5'h00;
            len_r <= NOM;
        end else if (tick_c) begin
            idx_r <= (idx_r == LAST_IDX) ? 5'h00 : idx_r + 1'b1; // R1
            if (idx_r == PRE_IDX) begin
                len_r <= trim_code[6] ? NOM - delta : NOM + delta; // R6 R7
            end else begin
                len_r <= NOM;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= tick_c;
        end
    end

    AST_PLAIN_LEN: assert property (idx_r != LAST_IDX |-> len_r == NOM) // R1
        else $error("uncorrected second has wrong length");
    AST_FAST_TRIM: assert property (tick_c && idx_r == PRE_IDX && trim_code == 7'h09 // R3
        |=> len_r == NOM + W'(8) * STEP)
        else $error("positive trim length wrong");
    AST_SLOW_TRIM: assert property (tick_c && idx_r == PRE_IDX && trim_code == 7'h7e // R4
        |=> len_r == NOM - W'(2) * STEP)
        else $error("negative trim length wrong");
    AST_NULL_TRIM: assert property (tick_c && idx_r == PRE_IDX // R5
        && (trim_code[5:0] == 6'h00 || trim_code == 7'h01 || trim_code == 7'h41)
        |=> len_r == NOM)
        else $error("null trim code changed length");
endmodule
`default_nettype wire

// ---- hw/rtsa_trim_supervisor_alarm.sv ----
`default_nettype none
// Contract
// R1: adjust the second count once in every 20-second interval from trim.
// R2: no correction when the six low trim bits are zero.
// R3: positive code: correction size is code minus one.
// R4: negative code: correction size is 80h minus code.
// R5: codes for 0, +1, -64 and -63 give no correction.
// R6: positive codes 02h to 3Fh lengthen seconds, slowing the count.
// R7: negative codes shorten seconds, speeding the count.
// R8: raw clock output is never touched by trim.
// R9: halt and low-supply flags stay one until software writes zero.
// R10: setting the halt flag clears the low-supply flag.
// R11: halt clears trim, enables, control bits, threshold, spare and all flags. The code sets the halt flag itself to one.
// R12: power-up reset sets the halt flag.
// R13: sample supply 7.8ms each second, threshold by select bit, flag drops.
// R14: no supply sampling while the low-supply flag is set.
// R15: alarm matches pull second pin (weekly) or third pin (daily) low.
// R16: flag bits at Fh D2..D0; enables D7, D6, select D2..D0 at Eh.
// R17: periodic select all zero disables the periodic first pin.
// R18: after power-up with enables zero all three pins are released.
// R19: enable one arms its alarm; reading a flag shows it fired.
// R20: writing one to an alarm flag is ignored; zero clears it.
// R21: clearing an alarm flag keeps its enable; next match fires again.
// R22: host disables an alarm before changing its alarm time.
// R23: level mode holds the periodic pin low until flag written zero.
// R24: select codes: off, low, 2Hz, 1Hz, per second, minute, hour, month.
// R25: alarms compare once when the minute changes.
// R26: each pin is low only while its flag and enable are set; the first pin in low, 2Hz and 1Hz modes ignores its flag.
module rtsa_trim_supervisor_alarm #(
    parameter int OSC_PER_SEC = rtsa_pkg::OSC_HZ,
    parameter int SAMPLE_OSC_CYCLES = rtsa_pkg::SAMPLE_OSC_CYCLES
) (
    input wire logic clock,
    input wire logic srst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic osc_in,
    input wire logic osc_halt_detect,
    input wire logic supply_below_thresh,
    input wire logic [2:0] cur_dow,
    input wire logic [5:0] cur_hour,
    input wire logic [6:0] cur_minute,
    input wire logic [6:0] alarm_w_days,
    input wire logic [5:0] alarm_w_hour,
    input wire logic [6:0] alarm_w_minute,
    input wire logic [5:0] alarm_d_hour,
    input wire logic [6:0] alarm_d_minute,
    input wire logic minute_start,
    input wire logic hour_start,
    input wire logic month_start,
    output logic sec_tick,
    output logic raw_clock_out,
    output logic supply_sample_en,
    output logic threshold_select,
    output logic hour_24_mode,
    output logic clkout_disable_a,
    output logic clkout_disable_b,
    output logic test_mode,
    output logic irq_pin_first_out,
    output logic irq_pin_first_oe,
    output logic irq_pin_second_out,
    output logic irq_pin_second_oe,
    output logic irq_pin_third_out,
    output logic irq_pin_third_oe
);
    localparam int W = rtsa_pkg::PHASE_W;
    localparam logic [W-1:0] HALF = W'(OSC_PER_SEC / 2);
    localparam logic [W-1:0] QUART = W'(OSC_PER_SEC / 4);
    localparam logic [15:0] SMP_LAST = 16'(SAMPLE_OSC_CYCLES - 1);

    logic osc_s1, osc_s2, osc_s3;
    logic halt_s1, halt_s2;
    logic sup_s1, sup_s2;
    logic osc_edge;
    logic halt_now;
    logic [7:0] ctrl_r;
    logic [6:0] trim_r;
    logic thresh_r, spare_r, clkdis_a_r;
    logic osc_halt_r, low_supply_r;
    logic weekly_flag_r, daily_flag_r, per_flag_r;
    logic wr_ctl, wr_stat, wr_trim;
    logic [6:0] min_prev_r;
    logic min_changed, weekly_match, daily_match;
    logic weekly_set, daily_set, per_set, per_evt, per_pin;
    logic supply_drop_set, drop_seen_r;
    logic [15:0] smp_cnt_r;
    logic [2:0] irq_oe_r;
    logic [7:0] stat_view;
    logic [W-1:0] sec_phase;
    rtsa_pkg::rtsa_psel_type psel;
    rtsa_pkg::rtsa_smp_type smp_state_r;

    default clocking @(posedge clock); endclocking
    default disable iff (srst);

    // pin synchronisers; stage one feeds only stage two. kept out of reset so they
    // track the pins through reset and no false oscillator edge follows its release
    always_ff @(posedge clock) begin
        osc_s1 <= osc_in;
        osc_s2 <= osc_s1;
        osc_s3 <= osc_s2;
        halt_s1 <= osc_halt_detect;
        halt_s2 <= halt_s1;
        sup_s1 <= supply_below_thresh;
        sup_s2 <= sup_s1;
    end

    assign osc_edge = osc_s2 && !osc_s3;
    assign halt_now = halt_s2;

    // raw clock follows the oscillator only, trim never reaches it
    always_ff @(posedge clock) begin
        if (srst) begin
            raw_clock_out <= 1'b0;
        end else begin
            raw_clock_out <= osc_s2; // R8
        end
    end

    rtsa_sec_gen #(
        .OSC_PER_SEC(OSC_PER_SEC)
    ) u_sec_gen (
        .clock(clock),
        .srst(srst),
        .osc_edge(osc_edge),
        .trim_code(trim_r),
        .sec_tick(sec_tick),
        .sec_phase(sec_phase)
    );

    assign wr_ctl = reg_wr && (reg_addr == rtsa_pkg::ADDR_IRQ_CTRL);
    assign wr_stat = reg_wr && (reg_addr == rtsa_pkg::ADDR_IRQ_STAT);
    assign wr_trim = reg_wr && (reg_addr == rtsa_pkg::ADDR_TRIM);

    // a halt wipes configuration and wins over a write in the same cycle
    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            ctrl_r <= rtsa_pkg::CTRL_RST; // R11
        end else if (wr_ctl) begin
            ctrl_r <= reg_wdata; // R16 R19
        end
    end

    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            trim_r <= rtsa_pkg::TRIM_RST; // R11
        end else if (wr_trim) begin
            trim_r <= reg_wdata[6:0];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            thresh_r <= 1'b0; // R11
            spare_r <= 1'b0;
            clkdis_a_r <= 1'b0;
        end else if (wr_stat) begin
            thresh_r <= reg_wdata[rtsa_pkg::STAT_THRESH];
            spare_r <= reg_wdata[rtsa_pkg::STAT_SPARE];
            clkdis_a_r <= reg_wdata[rtsa_pkg::STAT_CLKDIS_A];
        end
    end

    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            osc_halt_r <= 1'b1; // R12
        end else if (wr_stat && !reg_wdata[rtsa_pkg::STAT_HALT]) begin
            osc_halt_r <= 1'b0; // R9
        end
    end

    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            low_supply_r <= 1'b0; // R10
        end else begin
            low_supply_r <= supply_drop_set
                || (low_supply_r && !(wr_stat && !reg_wdata[rtsa_pkg::STAT_LOWSUP])); // R9
        end
    end

    // supply sampler: one window per second, parked while a drop is recorded
    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            smp_state_r <= rtsa_pkg::SMP_WAIT;
            smp_cnt_r <= 16'h0000;
            drop_seen_r <= 1'b0;
        end else begin
            case (smp_state_r)
                rtsa_pkg::SMP_WAIT: begin
                    if (sec_tick && !low_supply_r) begin
                        smp_state_r <= rtsa_pkg::SMP_RUN; // R13 R14
                        smp_cnt_r <= 16'h0000;
                        drop_seen_r <= 1'b0;
                    end
                end
                rtsa_pkg::SMP_RUN: begin
                    if (low_supply_r) begin
                        smp_state_r <= rtsa_pkg::SMP_WAIT; // R14
                    end else begin
                        drop_seen_r <= drop_seen_r || sup_s2;
                        if (osc_edge) begin
                            smp_cnt_r <= smp_cnt_r + 1'b1;
                            if (smp_cnt_r == SMP_LAST) begin
                                smp_state_r <= rtsa_pkg::SMP_EVAL;
                            end
                        end
                    end
                end
                rtsa_pkg::SMP_EVAL: begin
                    smp_state_r <= rtsa_pkg::SMP_WAIT;
                end
                default: begin
                    smp_state_r <= rtsa_pkg::SMP_WAIT;
                end
            endcase
        end
    end

    assign supply_drop_set = (smp_state_r == rtsa_pkg::SMP_EVAL) && drop_seen_r; // R13
    assign supply_sample_en = (smp_state_r == rtsa_pkg::SMP_RUN);

    // alarms look once per new minute so a cleared flag is not re-fired
    always_ff @(posedge clock) begin
        if (srst) begin
            min_prev_r <= 7'h00;
        end else begin
            min_prev_r <= cur_minute;
        end
    end

    assign min_changed = (cur_minute != min_prev_r); // R25
    assign weekly_match = (cur_dow < 3'h7) && alarm_w_days[cur_dow]
        && (cur_hour == alarm_w_hour) && (cur_minute == alarm_w_minute);
    assign daily_match = (cur_hour == alarm_d_hour) && (cur_minute == alarm_d_minute);
    assign weekly_set = min_changed && weekly_match && ctrl_r[rtsa_pkg::CTL_WEEKLY_EN]; // R15
    assign daily_set = min_changed && daily_match && ctrl_r[rtsa_pkg::CTL_DAILY_EN]; // R15

    // a set in the same cycle as a zero write wins
    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            weekly_flag_r <= 1'b0; // R11
            daily_flag_r <= 1'b0;
        end else begin
            weekly_flag_r <= weekly_set
                || (weekly_flag_r && !(wr_stat && !reg_wdata[rtsa_pkg::STAT_WFLAG])); // R20
            daily_flag_r <= daily_set
                || (daily_flag_r && !(wr_stat && !reg_wdata[rtsa_pkg::STAT_DFLAG])); // R20
        end
    end

    assign psel = rtsa_pkg::rtsa_psel_type'(ctrl_r[rtsa_pkg::CTL_PSEL_MSB:0]);

    always_comb begin
        per_evt = 1'b0;
        case (psel)
            rtsa_pkg::PSEL_SEC: per_evt = sec_tick; // R24
            rtsa_pkg::PSEL_MIN: per_evt = minute_start;
            rtsa_pkg::PSEL_HOUR: per_evt = hour_start;
            rtsa_pkg::PSEL_MONTH: per_evt = month_start;
            default: per_evt = 1'b0;
        endcase
    end

    assign per_set = per_evt;

    always_ff @(posedge clock) begin
        if (srst || halt_now) begin
            per_flag_r <= 1'b0; // R11
        end else begin
            per_flag_r <= per_set
                || (per_flag_r && !(wr_stat && !reg_wdata[rtsa_pkg::STAT_PFLAG])); // R23
        end
    end

    // pulse modes use the trimmed second phase, so a corrected second lengthens or shortens them
    always_comb begin
        per_pin = 1'b0;
        case (psel)
            rtsa_pkg::PSEL_OFF: per_pin = 1'b0; // R17
            rtsa_pkg::PSEL_LOW: per_pin = 1'b1; // R24
            rtsa_pkg::PSEL_2HZ: per_pin = (sec_phase < QUART)
                || ((sec_phase >= HALF) && (sec_phase < HALF + QUART));
            rtsa_pkg::PSEL_1HZ: per_pin = (sec_phase < HALF);
            default: per_pin = per_flag_r; // R23
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            irq_oe_r <= 3'h0; // R18
        end else begin
            irq_oe_r[0] <= per_pin;
            irq_oe_r[1] <= weekly_flag_r && ctrl_r[rtsa_pkg::CTL_WEEKLY_EN]; // R26
            irq_oe_r[2] <= daily_flag_r && ctrl_r[rtsa_pkg::CTL_DAILY_EN]; // R26
        end
    end

    assign irq_pin_first_oe = irq_oe_r[0];
    assign irq_pin_second_oe = irq_oe_r[1];
    assign irq_pin_third_oe = irq_oe_r[2];
    assign irq_pin_first_out = 1'b0;
    assign irq_pin_second_out = 1'b0;
    assign irq_pin_third_out = 1'b0;

    assign threshold_select = thresh_r;
    assign hour_24_mode = ctrl_r[rtsa_pkg::CTL_HOUR24];
    assign clkout_disable_a = clkdis_a_r;
    assign clkout_disable_b = ctrl_r[rtsa_pkg::CTL_CLKDIS_B];
    assign test_mode = ctrl_r[rtsa_pkg::CTL_TEST];

    always_comb begin
        stat_view = 8'h00;
        stat_view[rtsa_pkg::STAT_THRESH] = thresh_r;
        stat_view[rtsa_pkg::STAT_LOWSUP] = low_supply_r;
        stat_view[rtsa_pkg::STAT_HALT] = osc_halt_r;
        stat_view[rtsa_pkg::STAT_SPARE] = spare_r;
        stat_view[rtsa_pkg::STAT_CLKDIS_A] = clkdis_a_r;
        stat_view[rtsa_pkg::STAT_PFLAG] = per_flag_r;
        stat_view[rtsa_pkg::STAT_WFLAG] = weekly_flag_r; // R19
        stat_view[rtsa_pkg::STAT_DFLAG] = daily_flag_r;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                rtsa_pkg::ADDR_IRQ_CTRL: reg_rdata <= ctrl_r;
                rtsa_pkg::ADDR_IRQ_STAT: reg_rdata <= stat_view;
                rtsa_pkg::ADDR_TRIM: reg_rdata <= {1'b0, trim_r};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    AST_HALT_HOLD: assert property (osc_halt_r && !(wr_stat // R9
        && !reg_wdata[rtsa_pkg::STAT_HALT]) |=> osc_halt_r)
        else $error("halt flag dropped without a zero write");
    AST_HALT_LOWSUP: assert property ($rose(osc_halt_r) |-> !low_supply_r) // R10
        else $error("low-supply flag survived a halt");
    AST_HALT_WIPE: assert property (halt_now |=> ctrl_r == 8'h00 && trim_r == 7'h00 // R11
        && !per_flag_r && !weekly_flag_r && !daily_flag_r && !thresh_r && !spare_r)
        else $error("halt did not clear configuration");
    AST_POR_HALT: assert property ($fell(srst) |-> osc_halt_r && irq_oe_r == 3'h0) // R12
        else $error("reset release without halt flag or with pins low");
    AST_SAMPLE_STOP: assert property (low_supply_r |-> !supply_sample_en) // R14
        else $error("sampling while a drop is recorded");
    AST_PIN_WEEKLY: assert property (1'b1 |=> irq_pin_second_oe // R26
        == $past(weekly_flag_r && ctrl_r[rtsa_pkg::CTL_WEEKLY_EN]))
        else $error("second pin does not follow flag and enable");
    AST_W1_IGNORED: assert property (wr_stat && reg_wdata[rtsa_pkg::STAT_WFLAG] // R20
        && !weekly_flag_r && !weekly_set |=> !weekly_flag_r)
        else $error("writing one set the weekly flag");
    AST_EN_KEEP: assert property (wr_stat && !wr_ctl && !halt_now // R21
        |=> ctrl_r == $past(ctrl_r))
        else $error("status write changed enables");
    AST_PER_OFF: assert property (psel == rtsa_pkg::PSEL_OFF |=> !irq_pin_first_oe) // R17
        else $error("periodic pin low while disabled");
    AST_LEVEL_HOLD: assert property (per_flag_r && ctrl_r[rtsa_pkg::CTL_PSEL_MSB] // R23
        |=> irq_pin_first_oe)
        else $error("level mode pin released with flag set");
    AST_ONCE_PER_MIN: assert property (!min_changed && !weekly_flag_r // R25
        |=> !weekly_flag_r)
        else $error("weekly alarm fired without a minute change");
endmodule
`default_nettype wire

// ---- include/rtsa_pkg.sv ----
`default_nettype none
package rtsa_pkg;
    // register addresses on the internal register port
    localparam logic [3:0] ADDR_TRIM = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CTRL = 4'he;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'hf;

    // interrupt_enable_control fields
    localparam int CTL_WEEKLY_EN = 7;
    localparam int CTL_DAILY_EN = 6;
    localparam int CTL_HOUR24 = 5;
    localparam int CTL_CLKDIS_B = 4;
    localparam int CTL_TEST = 3;
    localparam int CTL_PSEL_MSB = 2;

    // interrupt_flag_status fields
    localparam int STAT_THRESH = 7;
    localparam int STAT_LOWSUP = 6;
    localparam int STAT_HALT = 5;
    localparam int STAT_SPARE = 4;
    localparam int STAT_CLKDIS_A = 3;
    localparam int STAT_PFLAG = 2;
    localparam int STAT_WFLAG = 1;
    localparam int STAT_DFLAG = 0;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [6:0] TRIM_RST = 7'h00;

    // trim code encoding
    localparam logic [6:0] TRIM_POS_BASE = 7'h01;
    localparam logic [7:0] TRIM_NEG_BASE = 8'h80;
    localparam logic [6:0] TRIM_NEG_NULL = 7'h41;

    // timing
    localparam int OSC_HZ = 32768;
    localparam int TRIM_PERIOD_SEC = 20;
    localparam longint TRIM_STEP_PPB = 3050;
    // one trim step in oscillator cycles per correction interval, rounded to nearest
    localparam int TRIM_STEP_CYCLES = int'((TRIM_STEP_PPB * OSC_HZ * TRIM_PERIOD_SEC
        + 64'd500000000) / 64'd1000000000);
    localparam longint SAMPLE_TIME_US = 7800;
    // least sampling window, rounded up to whole oscillator cycles
    localparam int SAMPLE_OSC_CYCLES = int'((SAMPLE_TIME_US * OSC_HZ + 64'd999999)
        / 64'd1000000);
    localparam int PHASE_W = 18;

    typedef enum logic [2:0] {
        PSEL_OFF = 3'h0,
        PSEL_LOW = 3'h1,
        PSEL_2HZ = 3'h2,
        PSEL_1HZ = 3'h3,
        PSEL_SEC = 3'h4,
        PSEL_MIN = 3'h5,
        PSEL_HOUR = 3'h6,
        PSEL_MONTH = 3'h7
    } rtsa_psel_type;

    typedef enum logic [1:0] {
        SMP_WAIT = 2'h0,
        SMP_RUN = 2'h1,
        SMP_EVAL = 2'h3
    } rtsa_smp_type;
endpackage
`default_nettype wire

// ---- verif/rtsa_host_model.sv ----
`default_nettype none
module rtsa_host_model (
    input wire logic clock,
    output logic [3:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 4'h0;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        // released data lines must not keep the last value
        reg_wdata <= ~d;
    endtask
    task automatic sel(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
    endtask
endmodule
`default_nettype wire

// ---- verif/rtsa_trim_supervisor_alarm_tb.sv ----
`default_nettype none
module rtsa_trim_supervisor_alarm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, srst = 1, osc_in = 0, osc_halt_detect = 0, supply_below_thresh = 0;
    logic minute_start = 0, hour_start = 0, month_start = 0, rd_stb = 0, pin_stb = 0, osc_q = 0;
    logic reg_wr, sec_tick, irq_pin_first_oe, irq_pin_second_oe, irq_pin_third_oe;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [2:0] cur_dow = 0;
    logic [5:0] cur_hour = 0, alarm_w_hour = 0, alarm_d_hour = 0;
    logic [6:0] cur_minute = 0, alarm_w_minute = 0, alarm_d_minute = 0, alarm_w_days = 0;
    logic [7:0] rd_q[$];
    logic [2:0] pin_q[$];
    logic [31:0] seed = 57;
    int n_errors = 0, cmp_count = 0, osc_cnt = 0;

    rtsa_trim_supervisor_alarm #(.OSC_PER_SEC(64), .SAMPLE_OSC_CYCLES(4)) i_dut (
        .clock, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .osc_in, .osc_halt_detect,
        .supply_below_thresh, .cur_dow, .cur_hour, .cur_minute, .alarm_w_days, .alarm_w_hour,
        .alarm_w_minute, .alarm_d_hour, .alarm_d_minute, .minute_start, .hour_start,
        .month_start, .sec_tick, .raw_clock_out(), .supply_sample_en(), .threshold_select(),
        .hour_24_mode(), .clkout_disable_a(), .clkout_disable_b(), .test_mode(),
        .irq_pin_first_out(), .irq_pin_first_oe, .irq_pin_second_out(), .irq_pin_second_oe,
        .irq_pin_third_out(), .irq_pin_third_oe);
    rtsa_host_model i_host (.clock, .reg_addr, .reg_wr, .reg_wdata);

    initial forever #12.5 clock = ~clock;
    initial forever #100 osc_in = ~osc_in;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // osc edges are counted here so trim length is judged independently of the dut
    always @(posedge clock) begin
        osc_q <= osc_in;
        if (osc_in && !osc_q) osc_cnt <= osc_cnt + 1;
        if (rd_stb) chk({8'h0, reg_rdata}, {8'h0, rd_q.pop_front()}, "read");
        if (pin_stb) chk({13'h0, irq_pin_third_oe, irq_pin_second_oe, irq_pin_first_oe},
            {13'h0, pin_q.pop_front()}, "pins");
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        i_host.sel(a);
        rd_q.push_back(e);
        rd_stb <= 1;
        @(posedge clock);
        rd_stb <= 0;
    endtask
    task automatic pins(input logic [2:0] e);
        cyc(4);
        pin_q.push_back(e);
        pin_stb <= 1;
        @(posedge clock);
        pin_stb <= 0;
    endtask
    task automatic tick(output int c);
        for (int i = 0; i < 3000 && sec_tick !== 1'b1; i++) @(negedge clock);
        if (sec_tick !== 1'b1) n_errors++;
        @(negedge clock);
        c = osc_cnt;
        @(posedge clock);
    endtask
    task automatic test_done();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #2400us;
        n_errors++;
        test_done();
    end

    initial begin
        int k, d, c0, c1;
        logic [6:0] m;
        logic [7:0] e;
        static logic [7:0] tc[4] = '{8'h09, 8'h7e, 8'h41, 8'h40};
        static int tx[4] = '{16, -4, 0, 0};
        cyc(16);
        srst <= 0;
        rd(4'hf, 8'h20);
        rd(4'he, 8'h00);
        rd(4'h3, 8'h00);
        pins(3'b000);
        i_host.wr(4'hf, 8'hff);
        rd(4'hf, 8'hb8);
        i_host.wr(4'hf, 8'h00);
        rd(4'hf, 8'h00);
        $display("test regs done");
        for (k = 0; k < 2; k++) begin
            m = 7'(rnd() % 59 + 1);
            d = int'(rnd() % 7);
            e = k ? 8'h40 : 8'h80;
            i_host.wr(4'he, 8'h00);
            cur_dow <= 3'(d);
            alarm_w_days <= 7'(1 << d);
            cur_hour <= 6'(rnd() % 24);
            cur_minute <= m - 7'd1;
            alarm_w_minute <= m;
            alarm_d_minute <= m;
            @(posedge clock);
            alarm_w_hour <= cur_hour;
            alarm_d_hour <= cur_hour;
            i_host.wr(4'he, e);
            cur_minute <= m;
            pins(k ? 3'b100 : 3'b010);
            rd(4'hf, k ? 8'h01 : 8'h02);
            i_host.wr(4'hf, 8'h00);
            pins(3'b000);
            rd(4'he, e);
            cur_minute <= m - 7'd1;
            cyc(2);
            cur_minute <= m;
            pins(k ? 3'b100 : 3'b010);
            i_host.wr(4'he, 8'h00);
            i_host.wr(4'hf, 8'h00);
        end
        $display("test alarms done");
        for (k = 4; k < 8; k++) begin
            i_host.wr(4'he, 8'(k));
            if (k == 4) tick(c0);
            else begin
                {month_start, hour_start, minute_start} <= 3'(1 << (k - 5));
                @(posedge clock);
                {month_start, hour_start, minute_start} <= 3'b000;
            end
            pins(3'b001);
            rd(4'hf, 8'h04);
            i_host.wr(4'hf, 8'h00);
            pins(3'b000);
        end
        for (k = 2; k < 4; k++) begin
            i_host.wr(4'he, 8'(k));
            tick(c0);
            pins(3'b001);
            cyc(k == 2 ? 150 : 300);
            pins(3'b000);
            if (k == 2) begin
                cyc(150);
                pins(3'b001);
            end
        end
        i_host.wr(4'he, 8'h01);
        pins(3'b001);
        i_host.wr(4'he, 8'h00);
        pins(3'b000);
        $display("test periodic done");
        i_host.wr(4'he, 8'hff);
        i_host.wr(4'h7, 8'hff);
        rd(4'h7, 8'h7f);
        osc_halt_detect <= 1;
        cyc(8);
        osc_halt_detect <= 0;
        rd(4'hf, 8'h20);
        rd(4'he, 8'h00);
        rd(4'h7, 8'h00);
        i_host.wr(4'hf, 8'h00);
        supply_below_thresh <= 1;
        tick(c0);
        cyc(60);
        supply_below_thresh <= 0;
        rd(4'hf, 8'h40);
        tick(c0);
        cyc(60);
        rd(4'hf, 8'h40);
        osc_halt_detect <= 1;
        cyc(8);
        osc_halt_detect <= 0;
        rd(4'hf, 8'h20);
        i_host.wr(4'hf, 8'h00);
        $display("test supervisor done");
        for (k = 0; k < 4; k++) begin
            i_host.wr(4'h7, tc[k]);
            tick(c0);
            repeat (20) tick(c1);
            chk(16'(c1 - c0), 16'(1280 + tx[k]), "osc edges");
        end
        $display("test trim done");
        cyc(4);
        test_done();
    end
endmodule
`default_nettype wire
